// *** core/fbsq_top.sv ***
`timescale 1ns/100ps
`include "fbsq_params.svh"
module fbsq_top #(
  parameter int NHEADS    = 8,
  parameter int WD_CYC    = `FBSQ_WD_CYC,
  parameter int BLINK_CYC = `FBSQ_BLINK_CYC
) (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Bus line
  input  wire logic                        i_rxd,
  output logic                             o_txd,
  output logic                             o_txd_oe,
  // Panel and sensor side
  input  wire logic [6:0]                  i_station_addr,
  input  wire logic                        i_trigger,
  input  wire logic [15:0]                 i_box_temp,
  input  wire fbsq_pkg::fbsq_head_s [NHEADS-1:0] i_heads,
  // Parameter output
  input  wire logic [7:0]                  i_par_raddr,
  output logic      [7:0]                  o_par_rdata,
  output logic                             o_par_upd,
  // Indicators
  output logic                             o_led_red,
  output logic                             o_led_yel,
  output logic                             o_data_ex
);

  localparam int         IN_LEN  = 3 + 4 * NHEADS;
  localparam int         OUT_LEN = 4 * NHEADS;
  localparam logic [7:0] IN_L8   = 8'(IN_LEN);
  localparam logic [7:0] OUT_L8  = 8'(OUT_LEN);
  localparam logic [12:0] BMIN   = 13'(`FBSQ_BIT_MIN_CYC);
  localparam logic [12:0] BMAX   = 13'(`FBSQ_BIT_MAX_CYC);

  // ----------------------------------------------------------------
  // Line input and bit rate
  // ----------------------------------------------------------------
  logic [2:0]  rx_sync_ff;
  logic        rx_lvl_ff;
  logic        rx_prev_ff;
  logic [12:0] low_cnt_ff;
  logic [12:0] bit_cyc_ff;
  logic        wd_exp;
  logic        tx_busy_ff;

  // Three stages; a level counts once the last two agree.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_sync_ff <= `FBSQ_RX_IDLE;
      rx_lvl_ff  <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_sync_ff <= {rx_sync_ff[1:0], i_rxd};
      rx_prev_ff <= rx_lvl_ff;
      if (rx_sync_ff[2] == rx_sync_ff[1]) begin
        rx_lvl_ff <= rx_sync_ff[2];
      end
    end
  end

  // The shortest low run seen is one bit time; runs below the fastest rate are glitches.
  // bit rate hunt
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_ff <= 13'h0000;
      bit_cyc_ff <= BMAX;
    end else begin
      if (!rx_lvl_ff && low_cnt_ff != 13'h1FFF) begin
        low_cnt_ff <= low_cnt_ff + 13'h0001;
      end else if (rx_lvl_ff) begin
        low_cnt_ff <= 13'h0000;
      end
      if (wd_exp) begin
        bit_cyc_ff <= BMAX;
      end else if (rx_lvl_ff && !rx_prev_ff && low_cnt_ff >= BMIN && low_cnt_ff < bit_cyc_ff) begin
        bit_cyc_ff <= low_cnt_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte receiver
  // ----------------------------------------------------------------
  logic              rx_busy_ff;
  logic [12:0]       rx_tmr_ff;
  logic [3:0]        rx_bit_ff;
  logic [7:0]        rx_sh_ff;
  fbsq_pkg::fbsq_rxb_s rxb_ff;

  // Samples mid-bit; the line is ignored while we drive it (half duplex).
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_busy_ff <= 1'b0;
      rx_tmr_ff  <= 13'h0000;
      rx_bit_ff  <= 4'h0;
      rx_sh_ff   <= 8'h00;
      rxb_ff     <= '0;
    end else begin
      rxb_ff.valid <= 1'b0;
      if (!rx_busy_ff) begin
        if (rx_prev_ff && !rx_lvl_ff && !tx_busy_ff) begin
          rx_busy_ff <= 1'b1;
          rx_tmr_ff  <= {1'b0, bit_cyc_ff[12:1]};
          rx_bit_ff  <= 4'h0;
        end
      end else if (rx_tmr_ff != 13'h0000) begin
        rx_tmr_ff <= rx_tmr_ff - 13'h0001;
      end else begin
        rx_tmr_ff <= bit_cyc_ff - 13'h0001;
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0 && rx_lvl_ff) begin
          rx_busy_ff <= 1'b0;
        end else if (rx_bit_ff == 4'h9) begin
          rx_busy_ff   <= 1'b0;
          rxb_ff.valid <= rx_lvl_ff;
          rxb_ff.data  <= rx_sh_ff;
        end else if (rx_bit_ff != 4'h0) begin
          rx_sh_ff <= {rx_lvl_ff, rx_sh_ff[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Telegram parser
  // ----------------------------------------------------------------
  fbsq_pkg::fbsq_pst_e   pst_ff;
  fbsq_pkg::fbsq_state_e st_ff;
  logic       fr_match_ff;
  logic [7:0] fr_func_ff;
  logic [7:0] fr_len_ff;
  logic [7:0] fr_idx_ff;
  logic       frm_done_ff;
  logic       mem_we;

  // Telegram: address, function, length, payload. Length frames it, so no gap timing.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pst_ff      <= fbsq_pkg::PS_ADDR;
      fr_match_ff <= 1'b0;
      fr_func_ff  <= 8'h00;
      fr_len_ff   <= 8'h00;
      fr_idx_ff   <= 8'h00;
      frm_done_ff <= 1'b0;
    end else begin
      frm_done_ff <= 1'b0;
      if (rxb_ff.valid) begin
        case (pst_ff)
          fbsq_pkg::PS_ADDR: begin
            fr_match_ff <= !rxb_ff.data[7] && rxb_ff.data[6:0] == i_station_addr &&
                           i_station_addr >= `FBSQ_ADDR_MIN && i_station_addr <= `FBSQ_ADDR_MAX;
            pst_ff      <= fbsq_pkg::PS_FUNC;
          end
          fbsq_pkg::PS_FUNC: begin
            fr_func_ff <= rxb_ff.data;
            pst_ff     <= fbsq_pkg::PS_LEN;
          end
          fbsq_pkg::PS_LEN: begin
            fr_len_ff <= rxb_ff.data;
            fr_idx_ff <= 8'h00;
            if (rxb_ff.data == 8'h00) begin
              frm_done_ff <= 1'b1;
              pst_ff      <= fbsq_pkg::PS_ADDR;
            end else begin
              pst_ff <= fbsq_pkg::PS_DATA;
            end
          end
          fbsq_pkg::PS_DATA: begin
            fr_idx_ff <= fr_idx_ff + 8'h01;
            if (fr_idx_ff + 8'h01 == fr_len_ff) begin
              frm_done_ff <= 1'b1;
              pst_ff      <= fbsq_pkg::PS_ADDR;
            end
          end
          default: begin
            pst_ff <= fbsq_pkg::PS_ADDR;
          end
        endcase
      end
    end
  end

  assign mem_we = rxb_ff.valid && pst_ff == fbsq_pkg::PS_DATA && fr_match_ff &&
                  fr_func_ff == `FBSQ_FN_DATA && st_ff == fbsq_pkg::ST_DATA_EX &&
                  fr_idx_ff < OUT_L8;

  fbsq_mem #(.W(8), .D(256), .AW(8)) u_par_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (fr_idx_ff),
    .i_wdata (rxb_ff.data),
    .i_raddr (i_par_raddr),
    .o_rdata (o_par_rdata)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [31:0] wd_cnt_ff;
  logic        good_data;
  logic        tx_go;
  logic [7:0]  nxt_func;
  fbsq_pkg::fbsq_rk_e nxt_kind;
  logic [7:0]  nxt_diag;

  assign good_data = fr_func_ff == `FBSQ_FN_DATA && st_ff == fbsq_pkg::ST_DATA_EX &&
                     fr_len_ff == OUT_L8;
  assign tx_go     = frm_done_ff && fr_match_ff && !tx_busy_ff;
  assign wd_exp    = st_ff == fbsq_pkg::ST_DATA_EX && wd_cnt_ff == 32'(WD_CYC - 1);

  // Pick the answer; anything outside the cyclic set is refused with a diagnosis.
  always_comb begin
    nxt_func = fr_func_ff | `FBSQ_FN_ACK_BIT;
    nxt_kind = fbsq_pkg::RK_ACK;
    nxt_diag = 8'h00;
    case (fr_func_ff)
      `FBSQ_FN_PRM: nxt_kind = fbsq_pkg::RK_ACK;
      `FBSQ_FN_CFG: begin
        if (st_ff != fbsq_pkg::ST_WAIT_CFG) begin
          nxt_kind = fbsq_pkg::RK_DIAG;
          nxt_diag = `FBSQ_DG_SEQ;
        end
      end
      `FBSQ_FN_DATA: begin
        if (good_data) begin
          nxt_kind = fbsq_pkg::RK_DATA;
        end else begin
          nxt_kind = fbsq_pkg::RK_DIAG;
          nxt_diag = (st_ff == fbsq_pkg::ST_DATA_EX) ? `FBSQ_DG_LEN : `FBSQ_DG_SEQ;
        end
      end
      default: begin
        nxt_kind = fbsq_pkg::RK_DIAG;
        nxt_diag = `FBSQ_DG_UNSUP;
      end
    endcase
    if (nxt_kind == fbsq_pkg::RK_DIAG) begin
      nxt_func = `FBSQ_FN_DIAG;
    end
  end

  // Phase changes; a parameter telegram restarts start-up from any phase.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff     <= fbsq_pkg::ST_WAIT_PRM;
      wd_cnt_ff <= 32'h00000000;
      o_par_upd <= 1'b0;
    end else begin
      o_par_upd <= 1'b0;
      wd_cnt_ff <= (st_ff == fbsq_pkg::ST_DATA_EX) ? wd_cnt_ff + 32'h00000001 : 32'h00000000;
      if (wd_exp) begin
        st_ff <= fbsq_pkg::ST_WAIT_PRM;
      end else if (frm_done_ff && fr_match_ff) begin
        if (fr_func_ff == `FBSQ_FN_PRM) begin
          st_ff <= fbsq_pkg::ST_WAIT_CFG;
        end else if (fr_func_ff == `FBSQ_FN_CFG && st_ff == fbsq_pkg::ST_WAIT_CFG) begin
          st_ff <= fbsq_pkg::ST_DATA_EX;
        end else if (good_data) begin
          o_par_upd <= 1'b1;
          wd_cnt_ff <= 32'h00000000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Answer transmitter
  // ----------------------------------------------------------------
  logic [8*IN_LEN-1:0] in_vec;
  logic [8*IN_LEN-1:0] snap_ff;
  logic [8*IN_LEN-1:0] snap_sh;
  fbsq_pkg::fbsq_rk_e  tx_kind_ff;
  logic [7:0]  tx_func_ff;
  logic [7:0]  tx_diag_ff;
  logic [7:0]  tx_idx_ff;
  logic [7:0]  tx_total;
  logic [3:0]  tx_bit_ff;
  logic [12:0] tx_tmr_ff;
  logic [7:0]  tx_byte;
  logic [9:0]  tx_frm;

  assign in_vec[7:0]  = {7'h00, i_trigger};
  assign in_vec[23:8] = {i_box_temp[7:0], i_box_temp[15:8]};
  for (genvar h = 0; h < NHEADS; h++) begin : g_head
    assign in_vec[24+32*h +: 32] = {i_heads[h].head_temp[7:0], i_heads[h].head_temp[15:8],
                                    i_heads[h].obj_temp[7:0], i_heads[h].obj_temp[15:8]};
  end

  assign snap_sh  = snap_ff >> {tx_idx_ff - 8'h02, 3'h0};
  assign tx_total = (tx_kind_ff == fbsq_pkg::RK_DATA) ? IN_L8 + 8'h02 :
                    (tx_kind_ff == fbsq_pkg::RK_DIAG) ? 8'h03 : 8'h02;
  assign tx_byte  = (tx_idx_ff == 8'h00) ? tx_func_ff :
                    (tx_idx_ff == 8'h01) ? tx_total - 8'h02 :
                    (tx_kind_ff == fbsq_pkg::RK_DIAG) ? tx_diag_ff : snap_sh[7:0];
  assign tx_frm   = {1'b1, tx_byte, 1'b0};

  // Temperatures are frozen at the answer's start so one answer is self-consistent.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_busy_ff <= 1'b0;
      tx_kind_ff <= fbsq_pkg::RK_ACK;
      tx_func_ff <= 8'h00;
      tx_diag_ff <= 8'h00;
      tx_idx_ff  <= 8'h00;
      tx_bit_ff  <= 4'h0;
      tx_tmr_ff  <= 13'h0000;
      snap_ff    <= '0;
      o_txd      <= 1'b1;
      o_txd_oe   <= 1'b0;
    end else if (!tx_busy_ff) begin
      o_txd    <= 1'b1;
      o_txd_oe <= 1'b0;
      if (tx_go) begin
        tx_busy_ff <= 1'b1;
        tx_kind_ff <= nxt_kind;
        tx_func_ff <= nxt_func;
        tx_diag_ff <= nxt_diag;
        snap_ff    <= in_vec;
        tx_idx_ff  <= 8'h00;
        tx_bit_ff  <= 4'h0;
        tx_tmr_ff  <= 13'h0000;
      end
    end else if (tx_tmr_ff != 13'h0000) begin
      tx_tmr_ff <= tx_tmr_ff - 13'h0001;
    end else if (tx_bit_ff == 4'hA) begin
      tx_bit_ff <= 4'h0;
      if (tx_idx_ff + 8'h01 == tx_total) begin
        tx_busy_ff <= 1'b0;
      end else begin
        tx_idx_ff <= tx_idx_ff + 8'h01;
      end
    end else begin
      o_txd_oe  <= 1'b1;
      o_txd     <= tx_frm[tx_bit_ff];
      tx_bit_ff <= tx_bit_ff + 4'h1;
      tx_tmr_ff <= bit_cyc_ff - 13'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  logic [31:0] blk_cnt_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      blk_cnt_ff <= 32'h00000000;
      o_led_red  <= 1'b0;
      o_led_yel  <= 1'b0;
      o_data_ex  <= 1'b0;
    end else begin
      o_led_yel <= st_ff == fbsq_pkg::ST_DATA_EX;
      o_data_ex <= st_ff == fbsq_pkg::ST_DATA_EX;
      if (st_ff == fbsq_pkg::ST_DATA_EX) begin
        blk_cnt_ff <= 32'h00000000;
        o_led_red  <= 1'b0;
      end else if (blk_cnt_ff == 32'(BLINK_CYC - 1)) begin
        blk_cnt_ff <= 32'h00000000;
        o_led_red  <= !o_led_red;
      end else begin
        blk_cnt_ff <= blk_cnt_ff + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_unsup;
    tx_go && !(fr_func_ff inside {`FBSQ_FN_PRM, `FBSQ_FN_CFG, `FBSQ_FN_DATA})
      |=> tx_kind_ff == fbsq_pkg::RK_DIAG && tx_diag_ff == `FBSQ_DG_UNSUP;
  endproperty
  a_unsup: assert property (p_unsup) else $error("acyclic request not refused");
  property p_prm;
    frm_done_ff && fr_match_ff && fr_func_ff == `FBSQ_FN_PRM && !wd_exp
      |=> st_ff == fbsq_pkg::ST_WAIT_CFG;
  endproperty
  a_prm: assert property (p_prm) else $error("parameters not taken");
  property p_cfg_order;
    $rose(st_ff == fbsq_pkg::ST_DATA_EX) |-> $past(st_ff) == fbsq_pkg::ST_WAIT_CFG;
  endproperty
  a_cfg_order: assert property (p_cfg_order) else $error("exchange skipped a step");
  property p_enter_ex;
    frm_done_ff && fr_match_ff && fr_func_ff == `FBSQ_FN_CFG && st_ff == fbsq_pkg::ST_WAIT_CFG
      |=> st_ff == fbsq_pkg::ST_DATA_EX ##1 o_data_ex;
  endproperty
  a_enter_ex: assert property (p_enter_ex) else $error("exchange not entered");
  property p_data_ans;
    tx_go && good_data && !wd_exp |=> tx_busy_ff && tx_kind_ff == fbsq_pkg::RK_DATA && o_par_upd;
  endproperty
  a_data_ans: assert property (p_data_ans) else $error("no input data answer");
  property p_par_wr;
    mem_we |-> st_ff == fbsq_pkg::ST_DATA_EX && fr_idx_ff < OUT_L8;
  endproperty
  a_par_wr: assert property (p_par_wr) else $error("parameter write out of place");
  property p_diag;
    tx_go && fr_func_ff == `FBSQ_FN_DATA && st_ff != fbsq_pkg::ST_DATA_EX
      |=> tx_kind_ff == fbsq_pkg::RK_DIAG && tx_func_ff == `FBSQ_FN_DIAG;
  endproperty
  a_diag: assert property (p_diag) else $error("error without diagnosis");
  property p_rate;
    bit_cyc_ff >= BMIN && bit_cyc_ff <= BMAX;
  endproperty
  a_rate: assert property (p_rate) else $error("bit time outside rate range");
  property p_addr;
    frm_done_ff && !fr_match_ff && !tx_busy_ff |=> !tx_busy_ff ##1 !o_txd_oe;
  endproperty
  a_addr: assert property (p_addr) else $error("answered foreign address");
  property p_len;
    tx_busy_ff && tx_kind_ff == fbsq_pkg::RK_DATA |-> tx_total == 8'(3 + 4 * NHEADS + 2);
  endproperty
  a_len: assert property (p_len) else $error("input data length wrong");
  property p_led;
    st_ff == fbsq_pkg::ST_DATA_EX |=> o_led_yel && !o_led_red;
  endproperty
  a_led: assert property (p_led) else $error("indicators wrong in exchange");
  property p_wd;
    wd_exp |=> st_ff == fbsq_pkg::ST_WAIT_PRM && bit_cyc_ff == BMAX;
  endproperty
  a_wd: assert property (p_wd) else $error("silent master not handled");

  c_ex:   cover property ($rose(st_ff == fbsq_pkg::ST_DATA_EX));
  c_data: cover property (o_par_upd);
  c_diag: cover property (tx_go && nxt_kind == fbsq_pkg::RK_DIAG);
  c_wd:   cover property (wd_exp);

endmodule : fbsq_top

// *** core/fbsq_params.svh ***
`ifndef FBSQ_PARAMS_SVH
`define FBSQ_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define FBSQ_CLK_HZ       50000000
`define FBSQ_BIT_MIN_NS   83
`define FBSQ_BIT_MAX_NS   104167
`define FBSQ_BIT_MIN_CYC  (`FBSQ_BIT_MIN_NS * (`FBSQ_CLK_HZ / 1000000) / 1000)
`define FBSQ_BIT_MAX_CYC  ((`FBSQ_BIT_MAX_NS * (`FBSQ_CLK_HZ / 1000000) + 999) / 1000)
`define FBSQ_WD_MS        100
`define FBSQ_WD_CYC       (`FBSQ_WD_MS * (`FBSQ_CLK_HZ / 1000))
`define FBSQ_BLINK_MS     250
`define FBSQ_BLINK_CYC    (`FBSQ_BLINK_MS * (`FBSQ_CLK_HZ / 1000))

// ----------------------------------------------------------------
// Telegram codes and address range
// ----------------------------------------------------------------
`define FBSQ_FN_PRM       8'h01
`define FBSQ_FN_CFG       8'h02
`define FBSQ_FN_DATA      8'h03
`define FBSQ_FN_DIAG      8'h04
`define FBSQ_FN_ACK_BIT   8'h80
`define FBSQ_DG_SEQ       8'h01
`define FBSQ_DG_LEN       8'h02
`define FBSQ_DG_UNSUP     8'h04
`define FBSQ_ADDR_MIN     7'h01
`define FBSQ_ADDR_MAX     7'h7D
`define FBSQ_RX_IDLE      3'h7

`endif

// *** core/fbsq_pkg.sv ***
package fbsq_pkg;

  // Slave start-up and exchange phases.
  typedef enum logic [1:0] {ST_WAIT_PRM, ST_WAIT_CFG, ST_DATA_EX} fbsq_state_e;

  // Telegram parser position.
  typedef enum logic [1:0] {PS_ADDR, PS_FUNC, PS_LEN, PS_DATA} fbsq_pst_e;

  // Kind of answer being sent.
  typedef enum logic [1:0] {RK_ACK, RK_DATA, RK_DIAG} fbsq_rk_e;

  // One sensing head's temperatures in 0.1 degree.
  typedef struct packed {
    logic [15:0] obj_temp;
    logic [15:0] head_temp;
  } fbsq_head_s;

  // A received byte.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fbsq_rxb_s;

endpackage : fbsq_pkg

// *** core/fbsq_mem.sv ***
`timescale 1ns/100ps
module fbsq_mem #(
  parameter int W  = 8,
  parameter int D  = 32,
  parameter int AW = 5
) (
  // Clock
  input  wire logic          i_clk,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);

  logic [W-1:0] mem [D];

  // Storage has no reset; the read register is what leaves the module.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule : fbsq_mem

// *** tb/fbsq_master_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Bus master model
// ----------------------------------------------------------------
module fbsq_master_model #(
  parameter int BIT = 8
) (
  // Clock
  input  wire logic i_clk,
  // Slave transmit side
  input  wire logic i_txd,
  input  wire logic i_txd_oe,
  // Master transmit line
  output logic      o_rxd
);
  // The line idles at the mark level between frames.
  initial o_rxd = 1'b1;

  // fixed unannounced rate
  // Start, eight bits LSB first, stop; the slave gets no rate setting at all.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd = f[i];
      repeat (BIT) @(negedge i_clk);
    end
  endtask : send_byte

  // Waits a bounded time for a start bit, then samples each bit mid-cell.
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (!(i_txd_oe === 1'b1 && i_txd === 1'b0) && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    ok = (n < 400);
    if (ok) begin
      repeat (BIT / 2) @(negedge i_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(negedge i_clk);
        b[i] = i_txd;
      end
      repeat (BIT) @(negedge i_clk);
    end
  endtask : recv_byte
endmodule : fbsq_master_model

// *** tb/fbsq_top_test.sv ***
`timescale 1ns/100ps
module fbsq_top_test;
  localparam int NH = 8;
  localparam int WD = 6000;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic                          i_clk, i_rst, i_rxd, o_txd, o_txd_oe, i_trigger, oe_q;
  logic                          o_par_upd, o_led_red, o_led_yel, o_data_ex;
  logic [6:0]                    i_station_addr;
  logic [15:0]                   i_box_temp;
  logic [7:0]                    i_par_raddr, o_par_rdata;
  fbsq_pkg::fbsq_head_s [NH-1:0] i_heads;
  int                            bad_count, comparisons, upd_count, rises;
  logic [7:0]                    q[$];

  fbsq_top #(.NHEADS(NH), .WD_CYC(WD), .BLINK_CYC(16)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_rxd(i_rxd), .o_txd(o_txd), .o_txd_oe(o_txd_oe),
    .i_station_addr(i_station_addr), .i_trigger(i_trigger), .i_box_temp(i_box_temp),
    .i_heads(i_heads), .i_par_raddr(i_par_raddr), .o_par_rdata(o_par_rdata),
    .o_par_upd(o_par_upd), .o_led_red(o_led_red), .o_led_yel(o_led_yel),
    .o_data_ex(o_data_ex));
  fbsq_master_model #(.BIT(8)) mdl (
    .i_clk(i_clk), .i_txd(o_txd), .i_txd_oe(o_txd_oe), .o_rxd(i_rxd));

  // Free-running clock, 20 ns period.
  always #10 i_clk = ~i_clk;

  // Counts update pulses and driver enable rises, so silence can be proven.
  always @(posedge i_clk) begin
    if (o_par_upd === 1'b1) upd_count++;
    if (o_txd_oe === 1'b1 && oe_q !== 1'b1) rises++;
    oe_q <= o_txd_oe;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits for the line to be free, since bytes during an answer are dropped.
  task automatic tel(input logic [6:0] a, input logic [7:0] f, input logic [7:0] len);
    int n;
    n = 0;
    while (o_txd_oe !== 1'b0 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    chk("line free", 16'h0000, {15'h0, o_txd_oe});
    repeat (4) @(negedge i_clk);
    mdl.send_byte({1'b0, a});
    mdl.send_byte(f);
    mdl.send_byte(len);
    for (int k = 0; k < len; k++) begin
      mdl.send_byte(8'hA0 + k[7:0]);
    end
  endtask : tel

  // Receives as many bytes as q holds; a missing byte fails its compare too.
  task automatic reply(input string what);
    logic [7:0] b;
    logic       ok;
    foreach (q[k]) begin
      mdl.recv_byte(b, ok);
      chk(what, {7'h00, 1'b1, q[k]}, {7'h00, ok, b});
    end
  endtask : reply

  task automatic blinks(input string what);
    logic last;
    int   n;
    n = 0;
    last = o_led_red;
    repeat (96) begin
      @(negedge i_clk);
      if (o_led_red !== last) n++;
      last = o_led_red;
    end
    chk(what, 16'h0001, {15'h0000, n >= 5 && n <= 7});
  endtask : blinks

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Idle levels, blinking, then rate learning with a resync filler telegram.
  task automatic t_reset;
    chk("txd idle", 16'h0001, {15'h0, o_txd});
    chk("oe idle", 16'h0000, {15'h0, o_txd_oe});
    chk("yellow", 16'h0000, {15'h0, o_led_yel});
    blinks("red idle");
    mdl.send_byte(8'h55);
    repeat (56000) @(negedge i_clk);
    mdl.send_byte(8'h00);
    mdl.send_byte(8'h01);
    mdl.send_byte(8'h00);
    $display("reset test done");
  endtask : t_reset

  // Out-of-order, unsupported and foreign-address telegrams.
  task automatic t_order;
    int r0;
    tel(7'h05, 8'h02, 8'h00);
    q = {8'h04, 8'h01, 8'h01};
    reply("cfg first diag");
    tel(7'h05, 8'h05, 8'h00);
    q = {8'h04, 8'h01, 8'h04};
    reply("unsupported diag");
    r0 = rises;
    tel(7'h06, 8'h01, 8'h00);
    repeat (200) @(negedge i_clk);
    chk("foreign silent", r0[15:0], rises[15:0]);
    // Address zero is outside the station range, so even a match stays silent.
    i_station_addr = 7'h00;
    tel(7'h00, 8'h01, 8'h00);
    repeat (200) @(negedge i_clk);
    chk("addr 0 silent", r0[15:0], rises[15:0]);
    i_station_addr = 7'h05;
    tel(7'h05, 8'h02, 8'h00);
    q = {8'h04, 8'h01, 8'h01};
    reply("state kept diag");
    $display("order test done");
  endtask : t_order

  task automatic t_start;
    tel(7'h05, 8'h01, 8'h00);
    q = {8'h81, 8'h00};
    reply("param ack");
    tel(7'h05, 8'h02, 8'h00);
    q = {8'h82, 8'h00};
    reply("config ack");
    repeat (4) @(negedge i_clk);
    chk("exchange", 16'h0001, {15'h0, o_data_ex});
    chk("yellow on", 16'h0001, {15'h0, o_led_yel});
    chk("red off", 16'h0000, {15'h0, o_led_red});
    $display("start test done");
  endtask : t_start

  task automatic t_data;
    logic [15:0] o;
    logic [15:0] t;
    tel(7'h05, 8'h03, 8'h04);
    q = {8'h04, 8'h01, 8'h02};
    reply("length diag");
    chk("no update", 16'h0000, upd_count[15:0]);
    // A cleared trigger must show up in the first input byte of the answer.
    i_trigger = 1'b0;
    tel(7'h05, 8'h03, 8'h20);
    q = {8'h83, 8'h23, 8'h00, 8'h01, 8'h23};
    for (int h = 0; h < NH; h++) begin
      o = 16'h1020 + 16'h0101 * h[15:0];
      t = 16'hC030 + 16'h0101 * h[15:0];
      q.push_back(o[15:8]);
      q.push_back(o[7:0]);
      q.push_back(t[15:8]);
      q.push_back(t[7:0]);
    end
    reply("input data");
    chk("one update", 16'h0001, upd_count[15:0]);
    for (int k = 0; k < 32; k++) begin
      i_par_raddr = k[7:0];
      repeat (2) @(negedge i_clk);
      chk("param byte", {8'h00, 8'hA0 + k[7:0]}, {8'h00, o_par_rdata});
    end
    chk("still exchange", 16'h0001, {15'h0, o_data_ex});
    $display("data test done");
  endtask : t_data

  // A silent master drops the slave back to waiting, with the red blink back.
  task automatic t_silence;
    int n;
    n = 0;
    while (o_data_ex === 1'b1 && n < WD + 500) begin
      @(negedge i_clk);
      n++;
    end
    chk("left exchange", 16'h0000, {15'h0, o_data_ex});
    chk("yellow off", 16'h0000, {15'h0, o_led_yel});
    blinks("red again");
    $display("silence test done");
  endtask : t_silence

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_station_addr = 7'h05;
    i_trigger = 1'b1;
    i_box_temp = 16'h0123;
    i_par_raddr = 8'h00;
    for (int h = 0; h < NH; h++) begin
      i_heads[h].obj_temp = 16'h1020 + 16'h0101 * h[15:0];
      i_heads[h].head_temp = 16'hC030 + 16'h0101 * h[15:0];
    end
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    t_reset();
    t_order();
    t_start();
    t_data();
    t_silence();
    wrap_up();
  end

  // Roughly 75k cycles are needed; cut the run at 100k.
  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end
endmodule : fbsq_top_test
